// ==== lbi_cfg_pkg.sv ====
package lbi_cfg_pkg;

   // ***********************************************
   // register map (byte addresses)
   // ***********************************************
   localparam logic [7:0] mask_window_off = 8'h78;
   localparam logic [7:0] status_off = 8'h7C;
   localparam logic [7:0] evt_status_off = 8'hA8;
   localparam logic [7:0] evt_mask_off = 8'hAC;
   localparam logic [7:0] mode_off = 8'hB8;

   // ***********************************************
   // reset values
   // ***********************************************
   localparam logic [31:0] mask_window_rst = 32'h00000000;
   localparam logic [31:0] status_rst = 32'h00000000;
   localparam logic [7:0] evt_mask_rst = 8'h00;
   localparam logic [2:0] mode_rst = 3'h0;

   // ***********************************************
   // field positions
   // ***********************************************
   localparam int window_b_pos = 24;
   localparam int window_a_pos = 16;
   localparam int mask_b_pos = 4;
   localparam int mask_a_pos = 0;
   localparam int hold_pos = 0;
   localparam int irq1_pos = 1;
   localparam int irq2_pos = 2;

   // ***********************************************
   // window codes
   // ***********************************************
   localparam logic [5:0] window_32 = 6'h20;
   localparam logic [5:0] window_16 = 6'h10;
   localparam logic [5:0] window_4 = 6'h04;
   localparam logic [5:0] window_2 = 6'h02;

   // per-channel mask field: all, tx pool, rx end, rx pool
   typedef struct packed {
      logic every;
      logic tx_pool;
      logic rx_end;
      logic rx_pool;
   } chan_mask_type;

   // peripheral event group for one channel
   typedef struct packed {
      logic tx_pool_ready_event;
      logic rx_message_end_event;
      logic rx_pool_full_event;
   } chan_evt_type;

   // pointer set selection
   typedef enum logic [1:0] {
      ptr_set_a,
      ptr_set_b,
      ptr_set_c,
      ptr_set_d
   } ptr_sel_type;

endpackage : lbi_cfg_pkg

// ==== lbi_evt_gate.sv ====
module lbi_evt_gate (
   // mask settings
   input wire lbi_cfg_pkg::chan_mask_type mask,
   input wire logic disregard,
   // raw events and gated result
   input wire lbi_cfg_pkg::chan_evt_type evt_in,
   output lbi_cfg_pkg::chan_evt_type evt_out
);
   // ***********************************************
   // per-channel masking
   // ***********************************************
   wire logic kill_all;
   wire logic [2:0] type_kill;
   assign kill_all = mask.every & ~disregard;
   // one driver for the whole group, so the output is never split between assigns
   assign type_kill = {mask.tx_pool, mask.rx_end, mask.rx_pool} & {3{~disregard}};
   // while disregard is low, masked types never reach the state machine or the queue
   assign evt_out = evt_in & ~type_kill & {3{~kill_all}};
endmodule : lbi_evt_gate

// ==== lbi_irq_cfg.sv ====
// Behaviour
// - each channel's rx fifo window field sets 32, 16, 4 or 2 accessible bytes by code.
// - suppress_every_irq_b set masks every channel B interrupt.
// - suppress_every_irq_a set masks every channel A interrupt.
// - channel B per-type suppress bits mask only their own event type.
// - channel A per-type suppress bits mask only their own event type.
// - pointer sets A/B serve interrupt mode A/B, sets C/D serve dma mode A/B.
// - with the framer peripheral only channel B carries data and channel A masks are ignored.
// - the status register is read only, resets to zero, bits above 15 read zero.
// - bus_hold_flag is 0 while the bus controller drives the bus and 1 in hold.
// - first_irq_line_flag is set when local_irq_input_1 is the pending source.
// - second_irq_line_flag is set when local_irq_input_2 is the pending source.
//
// The implementer's own choice: the AHB-Lite slave port.
module lbi_irq_cfg (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // bus controller status pins (asynchronous)
   input wire logic ext_bus_hold,
   input wire logic local_irq_input_1,
   input wire logic local_irq_input_2,
   // raw peripheral events from the transfer engine
   input wire lbi_cfg_pkg::chan_evt_type evt_a,
   input wire lbi_cfg_pkg::chan_evt_type evt_b,
   // gated events to the state machine and queue
   output lbi_cfg_pkg::chan_evt_type evt_a_gated,
   output lbi_cfg_pkg::chan_evt_type evt_b_gated,
   // pointer and window selection
   output lbi_cfg_pkg::ptr_sel_type ptr_sel_a,
   output lbi_cfg_pkg::ptr_sel_type ptr_sel_b,
   output logic [5:0] window_bytes_a,
   output logic [5:0] window_bytes_b,
   output logic window_legal_a,
   output logic window_legal_b,
   // interrupt
   output logic irq
);

   // ***********************************************
   // ahb address phase capture
   // ***********************************************
   logic wr_pend_r;
   logic rd_pend_r;
   logic [7:0] addr_r;
   wire logic xfer_ok;
   assign xfer_ok = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         wr_pend_r <= xfer_ok & hwrite;
         rd_pend_r <= xfer_ok & ~hwrite;
         if (xfer_ok) begin
            addr_r <= haddr[7:0];
         end
      end
   end
   // zero wait state slave, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_r <= 3'h0;
         pin_s2_r <= 3'h0;
      end else begin
         pin_s1_r <= {local_irq_input_2, local_irq_input_1, ext_bus_hold};
         pin_s2_r <= pin_s1_r;
      end
   end

   // ***********************************************
   // writable registers
   // ***********************************************
   logic [31:0] mask_window_r;
   logic [2:0] mode_r;
   logic [7:0] evt_mask_r;
   logic [7:0] evt_stat_r;
   logic [7:0] evt_stat_nxt;
   wire logic wr_mw;
   wire logic wr_mode;
   wire logic wr_emask;
   wire logic wr_estat;
   assign wr_mw = wr_pend_r & (addr_r == lbi_cfg_pkg::mask_window_off);
   assign wr_mode = wr_pend_r & (addr_r == lbi_cfg_pkg::mode_off);
   assign wr_emask = wr_pend_r & (addr_r == lbi_cfg_pkg::evt_mask_off);
   assign wr_estat = wr_pend_r & (addr_r == lbi_cfg_pkg::evt_status_off);

   // only documented bits are kept; unused bits read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_window_r <= lbi_cfg_pkg::mask_window_rst;
         mode_r <= lbi_cfg_pkg::mode_rst;
         evt_mask_r <= lbi_cfg_pkg::evt_mask_rst;
      end else begin
         if (wr_mw) begin
            mask_window_r <= hwdata & 32'h3F3F00FF;
         end
         if (wr_mode) begin
            mode_r <= hwdata[2:0];
         end
         if (wr_emask) begin
            evt_mask_r <= hwdata[7:0];
         end
      end
   end

   // ***********************************************
   // field decode
   // ***********************************************
   wire lbi_cfg_pkg::chan_mask_type mask_a;
   wire lbi_cfg_pkg::chan_mask_type mask_b;
   wire logic dma_mode_a;
   wire logic dma_mode_b;
   wire logic framer_mode;
   assign mask_a = mask_window_r[lbi_cfg_pkg::mask_a_pos +: 4];
   assign mask_b = mask_window_r[lbi_cfg_pkg::mask_b_pos +: 4];
   assign dma_mode_a = mode_r[0];
   assign dma_mode_b = mode_r[1];
   assign framer_mode = mode_r[2];

   // window legality check, shared by both channels
   function automatic logic window_ok(input logic [5:0] code);
      window_ok = (code == lbi_cfg_pkg::window_32) | (code == lbi_cfg_pkg::window_16)
         | (code == lbi_cfg_pkg::window_4) | (code == lbi_cfg_pkg::window_2);
   endfunction : window_ok

   // the code equals the byte count; reserved codes flagged, not fixed
   assign window_bytes_a = mask_window_r[lbi_cfg_pkg::window_a_pos +: 6];
   assign window_bytes_b = mask_window_r[lbi_cfg_pkg::window_b_pos +: 6];
   assign window_legal_a = window_ok(window_bytes_a);
   assign window_legal_b = window_ok(window_bytes_b);

   // interrupt mode uses sets a/b, dma mode sets c/d
   assign ptr_sel_a = dma_mode_a ? lbi_cfg_pkg::ptr_set_c : lbi_cfg_pkg::ptr_set_a;
   assign ptr_sel_b = dma_mode_b ? lbi_cfg_pkg::ptr_set_d : lbi_cfg_pkg::ptr_set_b;

   // ***********************************************
   // event masking
   // ***********************************************
   // channel a masks are ignored in framer mode
   lbi_evt_gate gate_a (
      .mask(mask_a),
      .disregard(framer_mode),
      .evt_in(evt_a),
      .evt_out(evt_a_gated)
   );
   lbi_evt_gate gate_b (
      .mask(mask_b),
      .disregard(1'b0),
      .evt_in(evt_b),
      .evt_out(evt_b_gated)
   );

   // ***********************************************
   // local bus status
   // ***********************************************
   wire logic [31:0] status_word;
   assign status_word = {29'h0, pin_s2_r[2], pin_s2_r[1], pin_s2_r[0]};

   // ***********************************************
   // sticky event status, write one to clear
   // ***********************************************
   wire logic [7:0] evt_raise;
   assign evt_raise = {2'h0, evt_b_gated, evt_a_gated};
   // set wins over a clear in the same cycle
   always_comb begin
      evt_stat_nxt = evt_stat_r;
      if (wr_estat) begin
         evt_stat_nxt = evt_stat_nxt & ~hwdata[7:0];
      end
      evt_stat_nxt = evt_stat_nxt | evt_raise;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_stat_r <= 8'h00;
      end else begin
         evt_stat_r <= evt_stat_nxt;
      end
   end
   assign irq = |(evt_stat_r & evt_mask_r);

   // ***********************************************
   // read data
   // ***********************************************
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (addr_r)
         lbi_cfg_pkg::mask_window_off: rd_mux = mask_window_r;
         lbi_cfg_pkg::status_off: rd_mux = status_word;
         lbi_cfg_pkg::evt_status_off: rd_mux = {24'h0, evt_stat_r};
         lbi_cfg_pkg::evt_mask_off: rd_mux = {24'h0, evt_mask_r};
         lbi_cfg_pkg::mode_off: rd_mux = {29'h0, mode_r};
         default: rd_mux = 32'h00000000;
      endcase
   end
   assign hrdata = rd_pend_r ? rd_mux : 32'h00000000;

endmodule : lbi_irq_cfg

// ==== lbi_irq_cfg_checker.sv ====
module lbi_irq_cfg_checker (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // events
   input wire lbi_cfg_pkg::chan_evt_type evt_a,
   input wire lbi_cfg_pkg::chan_evt_type evt_b,
   input wire lbi_cfg_pkg::chan_evt_type evt_a_gated,
   input wire lbi_cfg_pkg::chan_evt_type evt_b_gated,
   // selections
   input wire lbi_cfg_pkg::ptr_sel_type ptr_sel_a,
   input wire lbi_cfg_pkg::ptr_sel_type ptr_sel_b,
   input wire logic [5:0] window_bytes_a,
   input wire logic [5:0] window_bytes_b,
   input wire logic window_legal_a,
   input wire logic window_legal_b
);
   // ***********************
   // port relations
   // ***********************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // zero-wait slave, so a stall would hang software
   no_stall_a: assert property (hreadyout) else $error("slave stalled");
   okay_resp_a: assert property (!hresp) else $error("slave gave error");
   // masking only removes events, never invents them
   gate_sub_a: assert property ((evt_a_gated & ~evt_a) == 3'h0)
      else $error("chan a event invented");
   gateb_sub_a: assert property ((evt_b_gated & ~evt_b) == 3'h0)
      else $error("chan b event invented");
   ptr_a_a: assert property (ptr_sel_a inside {2'h0, 2'h2})
      else $error("chan a pointer set wrong");
   ptr_b_a: assert property (ptr_sel_b inside {2'h1, 2'h3})
      else $error("chan b pointer set wrong");
   win_a_a: assert property (
      window_legal_a == (window_bytes_a inside {6'h20, 6'h10, 6'h04, 6'h02}))
      else $error("chan a window flag wrong");
   win_b_a: assert property (
      window_legal_b == (window_bytes_b inside {6'h20, 6'h10, 6'h04, 6'h02}))
      else $error("chan b window flag wrong");
endmodule : lbi_irq_cfg_checker

// ==== lbi_periph_model.sv ====
module lbi_periph_model (
   // clock
   input wire logic hclk,
   // control from the bench
   input wire logic go,
   input wire logic [2:0] lines,
   // toward the device
   output lbi_cfg_pkg::chan_evt_type evt_a,
   output lbi_cfg_pkg::chan_evt_type evt_b,
   output logic ext_bus_hold,
   output logic local_irq_input_1,
   output logic local_irq_input_2
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] rnd_r;
   // fresh event pattern each cycle; quiet while idle
   always @(posedge hclk) rnd_r <= 6'($urandom);
   assign {evt_b, evt_a} = go ? rnd_r : 6'h00;
   // hold and line status as the controller reports them
   assign {local_irq_input_2, local_irq_input_1, ext_bus_hold} = lines;
endmodule : lbi_periph_model

// ==== lbi_irq_cfg_bench.sv ====
module lbi_irq_cfg_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, go;
   logic ext_bus_hold, local_irq_input_1, local_irq_input_2;
   logic window_legal_a, window_legal_b;
   logic [31:0] haddr, hwdata, hrdata, q, w, md, st;
   logic [1:0] htrans;
   logic [2:0] hsize, lines, ga, gb;
   logic [5:0] window_bytes_a, window_bytes_b;
   lbi_cfg_pkg::chan_evt_type evt_a, evt_b, evt_a_gated, evt_b_gated;
   lbi_cfg_pkg::ptr_sel_type ptr_sel_a, ptr_sel_b;
   logic [7:0] offs [6] = '{8'h78, 8'h7C, 8'hA8, 8'hAC, 8'hB8, 8'h40};
   logic [5:0] codes [6] = '{6'h20, 6'h10, 6'h04, 6'h02, 6'h32, 6'h00};
   int err_total, checks_done;
   assign hready = hreadyout;
   lbi_irq_cfg uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .ext_bus_hold, .local_irq_input_1,
      .local_irq_input_2, .evt_a, .evt_b, .evt_a_gated, .evt_b_gated, .ptr_sel_a,
      .ptr_sel_b, .window_bytes_a, .window_bytes_b, .window_legal_a, .window_legal_b, .irq);
   lbi_periph_model peer (.hclk, .go, .lines, .evt_a, .evt_b, .ext_bus_hold,
      .local_irq_input_1, .local_irq_input_2);
   // ***********************
   // helpers
   // ***********************
   function automatic logic [2:0] gate(input logic [3:0] mk, input logic [2:0] ev, input logic dis);
      if (dis) return ev;
      return mk[3] ? 3'h0 : ev & ~mk[2:0];
   endfunction : gate
   function automatic logic ok(input logic [5:0] c);
      return c inside {6'h20, 6'h10, 6'h04, 6'h02};
   endfunction : ok
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one single transfer; entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(q, exp);
   endtask : rd_chk
   task automatic irq_chk(input logic exp);
      @(negedge hclk);
      chk(32'(irq), 32'(exp));
      @(posedge hclk);
   endtask : irq_chk
   task automatic complete_run;
      if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   // clock, 4 ns period
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // watchdog far beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge hclk);
      err_total++;
      complete_run;
   end
   // main sequence
   initial begin
      err_total = 0;
      checks_done = 0;
      void'($urandom(32'hB6914705));
      {hresetn, hsel, hwrite, go} = 4'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      lines = 3'h0;
      st = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (offs[i]) rd_chk(offs[i], 32'h0);
      xfer(8'h7C, 1'b1, 32'hFFFFFFFF);
      for (int i = 0; i < 8; i++) begin
         lines <= i[2:0];
         repeat (4) @(posedge hclk);
         rd_chk(8'h7C, {29'h0, i[2:0]});
      end
      foreach (codes[i]) begin
         w = $urandom;
         w[29:24] = codes[i];
         w[21:16] = codes[5 - i];
         xfer(8'h78, 1'b1, w);
         rd_chk(8'h78, w & 32'h3F3F00FF);
         chk(32'({window_legal_b, window_bytes_b, window_legal_a, window_bytes_a}),
            32'({ok(w[29:24]), w[29:24], ok(w[21:16]), w[21:16]}));
      end
      // random masks and modes with live events
      xfer(8'hAC, 1'b1, 32'h0);
      repeat (12) begin
         // windows match the peripheral's own setup: 32 bytes on channel b, 16 bytes on channel a
         w = {8'h20, 8'h10, 8'h0, 8'($urandom)};
         md = $urandom & 32'h7;
         xfer(8'h78, 1'b1, w);
         xfer(8'hB8, 1'b1, md);
         // mode register lands on the edge that ends the write, so look half a cycle on
         @(negedge hclk);
         chk(32'({ptr_sel_a, ptr_sel_b}), {28'h0, md[0], 1'b0, md[1], 1'b1});
         @(posedge hclk);
         go <= 1'b1;
         repeat (6) begin
            @(negedge hclk);
            ga = gate(w[3:0], evt_a, md[2]);
            gb = gate(w[7:4], evt_b, 1'b0);
            chk(32'({evt_b_gated, evt_a_gated}), 32'({gb, ga}));
            st = st | {26'h0, gb, ga};
            @(posedge hclk);
         end
         go <= 1'b0;
      end
      // sticky status, masking and clearing of the interrupt
      rd_chk(8'hA8, st);
      xfer(8'hAC, 1'b1, {26'h0, ~st[5:0]});
      irq_chk(1'b0);
      xfer(8'hAC, 1'b1, 32'h3F);
      irq_chk(|st);
      xfer(8'hA8, 1'b1, st);
      rd_chk(8'hA8, 32'h0);
      irq_chk(1'b0);
      // bus logic reset after the configuration change brings every setting back to zero
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(8'h78, 32'h0);
      rd_chk(8'hB8, 32'h0);
      complete_run;
   end
endmodule : lbi_irq_cfg_bench
bind lbi_irq_cfg lbi_irq_cfg_checker watch (.hclk, .hresetn, .hreadyout, .hresp, .evt_a,
   .evt_b, .evt_a_gated, .evt_b_gated, .ptr_sel_a, .ptr_sel_b, .window_bytes_a,
   .window_bytes_b, .window_legal_a, .window_legal_b);
